// ---- hdl/bfc_ctrl.sv ----
// Supervisory logic of a step-down regulator: serial register port,
// soft-start sequencing, power-good, thermal and hiccup fault handling.
// Assumes analog comparators deliver level flags; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module bfc_ctrl #(
    parameter int DLY0_CYC = bfc_pkg::DLY0_US * bfc_pkg::CLK_MHZ,
    parameter int DLY1_CYC = bfc_pkg::DLY1_US * bfc_pkg::CLK_MHZ,
    parameter int DLY2_CYC = bfc_pkg::DLY2_US * bfc_pkg::CLK_MHZ,
    parameter int DLY3_CYC = bfc_pkg::DLY3_US * bfc_pkg::CLK_MHZ,
    parameter int COOL_CYC = bfc_pkg::COOL_US * bfc_pkg::CLK_MHZ,
    parameter bit WIDE_RANGE = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic en_i,
    input wire logic input_undervoltage_lockout_i,
    input wire logic pg_rise_i,
    input wire logic pg_fall_i,
    input wire logic temp_warn_i,
    input wire logic temp_shut_i,
    input wire logic temp_cool_i,
    input wire logic hiccup_i,
    input wire logic duty_max_i,
    input wire logic vout_low_i,
    output logic pg_o,
    output logic pg_oe_n_o,
    output logic switch_en_o,
    output logic hs_hold_o,
    output logic discharge_o,
    output logic [1:0] on_time_select_o,
    output logic [7:0] target_code_o,
    output logic [11:0] target_mv_o
);
    logic [11:0] s1_q, s2_q;
    logic scl_p_q, sda_p_q;
    logic scl_s, sda_s, en_s, input_undervoltage_lockout_s, rise_s, fall_s;
    logic warn_s, shut_s, cool_s, hic_s, duty_s, low_s;
    bfc_pkg::bfc_i2c_t ist_q;
    bfc_pkg::bfc_pwr_t st_q;
    logic [7:0] sh_q, tx_q, ptr_q, vout_q, control_reg_one_q, control_reg_two_q, rdval;
    logic [3:0] cnt_q;
    logic ackph_q, drv_q;
    logic scl_up, scl_dn, start_c, stop_c, byte_done, wr_stb;
    logic [15:0] dcnt_q;
    logic [1:0] tries_q;
    logic [11:0] scnt_q, step_cyc;
    logic [10:0] bcnt_q;
    logic pg_q, ot_q, warn_q, hold_q, disch_q, run_ok, fault_ev, active, want;

    // Two-stage synchronisers; only the second stage is read
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // Bus lines start at their idle high level so no false edge follows reset
            s1_q <= 12'hC00;
            s2_q <= 12'hC00;
        end
        else
        begin
            s1_q <= {scl_i, sda_i, en_i, input_undervoltage_lockout_i, pg_rise_i, pg_fall_i,
                     temp_warn_i, temp_shut_i, temp_cool_i, hiccup_i,
                     duty_max_i, vout_low_i};
            s2_q <= s1_q;
        end
    end
    assign {scl_s, sda_s, en_s, input_undervoltage_lockout_s, rise_s, fall_s, warn_s, shut_s,
            cool_s, hic_s, duty_s, low_s} = s2_q;

    // Previous bus levels for edge and start/stop detection
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end
    assign scl_up = scl_s & ~scl_p_q;
    assign scl_dn = ~scl_s & scl_p_q;
    assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
    assign byte_done = scl_dn & (cnt_q == 4'h8);
    assign wr_stb = byte_done & (ist_q == bfc_pkg::IS_WR);

    // Read data mux; unmapped pointers read zero
    always_comb
    begin
        case (ptr_q)
            bfc_pkg::REG_VOUT: rdval = vout_q;
            bfc_pkg::REG_CONTROL_REG_ONE: rdval = control_reg_one_q;
            bfc_pkg::REG_CONTROL_REG_TWO: rdval = control_reg_two_q;
            bfc_pkg::REG_FAULT: rdval = {2'b00, st_q == bfc_pkg::PS_LATCH, ot_q,
                                         warn_q, st_q == bfc_pkg::PS_COOL,
                                         st_q == bfc_pkg::PS_RUN, pg_q};
            default: rdval = 8'h00;
        endcase
    end

    // Serial slave; held idle only under lockout, enable is ignored
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ist_q <= bfc_pkg::IS_IDLE;
            cnt_q <= 4'h0;
            ackph_q <= 1'b0;
            drv_q <= 1'b0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
        end
        else if (input_undervoltage_lockout_s || stop_c)
        begin
            ist_q <= bfc_pkg::IS_IDLE;
            drv_q <= 1'b0;
        end
        else if (start_c)
        begin
            ist_q <= bfc_pkg::IS_ADDR;
            cnt_q <= 4'h0;
            ackph_q <= 1'b0;
            drv_q <= 1'b0;
        end
        else if (ist_q != bfc_pkg::IS_IDLE)
        begin
            if (scl_up)
            begin
                if (cnt_q == 4'h8)
                begin
                    cnt_q <= 4'h0;
                    // Master not-acknowledge ends a read
                    if (ist_q == bfc_pkg::IS_RD && sda_s && !drv_q)
                        ist_q <= bfc_pkg::IS_IDLE;
                end
                else
                begin
                    sh_q <= {sh_q[6:0], sda_s};
                    cnt_q <= cnt_q + 4'h1;
                end
            end
            else if (byte_done)
            begin
                ackph_q <= 1'b1;
                drv_q <= ist_q != bfc_pkg::IS_RD;
                case (ist_q)
                    bfc_pkg::IS_ADDR:
                    begin
                        if (sh_q[7:1] != bfc_pkg::I2C_ADDR)
                        begin
                            ist_q <= bfc_pkg::IS_IDLE;
                            drv_q <= 1'b0;
                        end
                        else if (sh_q[0])
                            ist_q <= bfc_pkg::IS_RD;
                        else
                            ist_q <= bfc_pkg::IS_PTR;
                    end
                    bfc_pkg::IS_PTR:
                    begin
                        ptr_q <= sh_q;
                        ist_q <= bfc_pkg::IS_WR;
                    end
                    bfc_pkg::IS_WR: ptr_q <= ptr_q + 8'h01;
                    default: ist_q <= ist_q;
                endcase
            end
            else if (scl_dn && ackph_q)
            begin
                ackph_q <= 1'b0;
                drv_q <= 1'b0;
                if (ist_q == bfc_pkg::IS_RD)
                begin
                    tx_q <= rdval;
                    drv_q <= ~rdval[7];
                    ptr_q <= ptr_q + 8'h01;
                end
            end
            else if (scl_dn && ist_q == bfc_pkg::IS_RD)
                drv_q <= ~tx_q[3'h7 - cnt_q[2:0]];
        end
    end
    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~drv_q;

    // Configuration; only power-on reset restores defaults
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            vout_q <= bfc_pkg::VOUT_RST;
            control_reg_one_q <= bfc_pkg::CONTROL_REG_ONE_RST;
            control_reg_two_q <= bfc_pkg::CONTROL_REG_TWO_RST;
        end
        else if (wr_stb)
        begin
            case (ptr_q)
                bfc_pkg::REG_VOUT: vout_q <= sh_q;
                bfc_pkg::REG_CONTROL_REG_ONE: control_reg_one_q <= sh_q;
                bfc_pkg::REG_CONTROL_REG_TWO: control_reg_two_q <= sh_q;
                default: vout_q <= vout_q;
            endcase
        end
    end
    assign on_time_select_o = control_reg_one_q[bfc_pkg::C1_TON_LSB +: 2];

    // Sequencer
    assign run_ok = en_s & control_reg_one_q[bfc_pkg::C1_SWEN] & ~input_undervoltage_lockout_s;
    assign active = (st_q == bfc_pkg::PS_RAMP) || (st_q == bfc_pkg::PS_RUN);
    assign fault_ev = active & (shut_s | hic_s);
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q <= bfc_pkg::PS_OFF;
            dcnt_q <= 16'h0000;
            tries_q <= 2'h0;
        end
        else if (!run_ok)
        begin
            st_q <= bfc_pkg::PS_OFF;
            tries_q <= 2'h0;
        end
        else
        begin
            case (st_q)
                bfc_pkg::PS_OFF:
                begin
                    st_q <= bfc_pkg::PS_DELAY;
                    case (control_reg_one_q[bfc_pkg::C1_DLY_LSB +: 2])
                        2'h0: dcnt_q <= 16'(DLY0_CYC);
                        2'h1: dcnt_q <= 16'(DLY1_CYC);
                        2'h2: dcnt_q <= 16'(DLY2_CYC);
                        default: dcnt_q <= 16'(DLY3_CYC);
                    endcase
                end
                bfc_pkg::PS_DELAY, bfc_pkg::PS_COOL:
                begin
                    if (dcnt_q != 16'h0000)
                        dcnt_q <= dcnt_q - 16'h0001;
                    else if (cool_s && !shut_s)
                        st_q <= bfc_pkg::PS_RAMP;
                end
                bfc_pkg::PS_RAMP, bfc_pkg::PS_RUN:
                begin
                    if (fault_ev)
                    begin
                        tries_q <= tries_q + 2'h1;
                        dcnt_q <= 16'(COOL_CYC);
                        if (tries_q == bfc_pkg::MAX_TRIES)
                            st_q <= bfc_pkg::PS_LATCH;
                        else if (shut_s && !control_reg_two_q[bfc_pkg::C2_OTRST])
                            st_q <= bfc_pkg::PS_LATCH;
                        else
                            st_q <= bfc_pkg::PS_COOL;
                    end
                    else if (st_q == bfc_pkg::PS_RAMP && target_code_o == vout_q)
                        st_q <= bfc_pkg::PS_RUN;
                    else if (pg_q)
                        tries_q <= 2'h0;
                end
                default: st_q <= st_q; // Latched until run_ok drops: enable, the switch-enable bit or lockout
            endcase
        end
    end
    assign switch_en_o = active;

    // Time per code step scales with step size on the wide variant
    always_comb
    begin
        step_cyc = 12'(bfc_pkg::RAMP_BASE_CYC)
                 + 12'(bfc_pkg::RAMP_INC_CYC) * {8'h00, control_reg_two_q[bfc_pkg::C2_SLEW_LSB +: 4]};
        if (WIDE_RANGE)
            step_cyc = (target_code_o >= bfc_pkg::WIDE_KNEE) ? step_cyc << 2 : step_cyc << 1;
    end

    // Target ramp; restarts from the lowest code after each off period
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            target_code_o <= 8'h00;
            scnt_q <= 12'h000;
        end
        else if (!active)
        begin
            target_code_o <= 8'h00;
            scnt_q <= 12'h000;
        end
        else if (target_code_o != vout_q)
        begin
            if (scnt_q + 12'h001 >= step_cyc)
            begin
                scnt_q <= 12'h000;
                if (target_code_o < vout_q)
                    target_code_o <= target_code_o + 8'h01;
                else
                    target_code_o <= target_code_o - 8'h01;
            end
            else
                scnt_q <= scnt_q + 12'h001;
        end
    end

    // Code to millivolt map for the analog reference
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            target_mv_o <= 12'h000;
        else if (!WIDE_RANGE)
            target_mv_o <= 12'd600 + 12'd5 * {4'h0, target_code_o};
        else if (target_code_o < bfc_pkg::WIDE_KNEE)
            target_mv_o <= 12'd600 + 12'd10 * {4'h0, target_code_o};
        else
            target_mv_o <= 12'd1280
                         + 12'd20 * {4'h0, target_code_o - bfc_pkg::WIDE_KNEE};
    end

    // Power-good with hysteresis via two comparators and a blanking filter
    assign want = pg_q ? ~fall_s : rise_s;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pg_q <= 1'b0;
            bcnt_q <= 11'h000;
        end
        else if (!run_ok || fault_ev || st_q != bfc_pkg::PS_RUN)
        begin
            pg_q <= 1'b0;
            bcnt_q <= 11'h000;
        end
        else if (want != pg_q)
        begin
            if (bcnt_q == 11'(bfc_pkg::BLANK_CYC - 1))
            begin
                pg_q <= want;
                bcnt_q <= 11'h000;
            end
            else
                bcnt_q <= bcnt_q + 11'h001;
        end
        else
            bcnt_q <= 11'h000;
    end
    assign pg_o = 1'b0;
    assign pg_oe_n_o = pg_q; // Pulls low whenever not good

    // Thermal flags; a new event wins over a host clear
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ot_q <= 1'b0;
            warn_q <= 1'b0;
        end
        else
        begin
            warn_q <= warn_s & ~shut_s & (st_q != bfc_pkg::PS_COOL);
            if (shut_s)
                ot_q <= 1'b1;
            else if (wr_stb && ptr_q == bfc_pkg::REG_FAULT && !sh_q[bfc_pkg::F_OT])
                ot_q <= 1'b0;
        end
    end

    // Full-duty hold and discharge switch
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hold_q <= 1'b0;
            disch_q <= 1'b0;
        end
        else
        begin
            disch_q <= control_reg_two_q[bfc_pkg::C2_DISCH] & ~active;
            if (st_q != bfc_pkg::PS_RUN || control_reg_two_q[bfc_pkg::C2_NOFULL] || fault_ev)
                hold_q <= 1'b0;
            else if (low_s)
                hold_q <= 1'b0;
            else if (duty_s)
                hold_q <= 1'b1;
        end
    end
    assign hs_hold_o = hold_q;
    assign discharge_o = disch_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_addr_hit;
        byte_done && ist_q == bfc_pkg::IS_ADDR && sh_q[7:1] == bfc_pkg::I2C_ADDR;
    endsequence
    property p_addr_ack;
        s_addr_hit |=> !sda_oe_n_o;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("no address ack");
    property p_pg_blank;
        $rose(pg_q) |-> $past(bcnt_q) == 11'(bfc_pkg::BLANK_CYC - 1);
    endproperty
    a_pg_blank: assert property (p_pg_blank) else $error("pg rose early");
    property p_pg_drop;
        !run_ok |=> !pg_q && pg_oe_n_o == 1'b0;
    endproperty
    a_pg_drop: assert property (p_pg_drop) else $error("pg not dropped");
    property p_pg_run;
        pg_q |-> st_q == bfc_pkg::PS_RUN;
    endproperty
    a_pg_run: assert property (p_pg_run) else $error("pg outside run");
    property p_input_undervoltage_lockout_off;
        input_undervoltage_lockout_s |=> !switch_en_o ##1 !switch_en_o;
    endproperty
    a_input_undervoltage_lockout_off: assert property (p_input_undervoltage_lockout_off) else $error("switch on in lockout");
    property p_shut_off;
        run_ok && active && shut_s |=> !switch_en_o;
    endproperty
    a_shut_off: assert property (p_shut_off) else $error("no thermal off");
    property p_ot_sticky;
        ot_q && !wr_stb |=> ot_q;
    endproperty
    a_ot_sticky: assert property (p_ot_sticky) else $error("ot lost");
    property p_first_latch;
        run_ok && active && shut_s && !control_reg_two_q[bfc_pkg::C2_OTRST] |=> st_q == bfc_pkg::PS_LATCH;
    endproperty
    a_first_latch: assert property (p_first_latch) else $error("no latch");
    property p_no_hold;
        control_reg_two_q[bfc_pkg::C2_NOFULL] |=> !hs_hold_o;
    endproperty
    a_no_hold: assert property (p_no_hold) else $error("hold while disabled");
endmodule
`default_nettype wire

// ---- hdl/bfc_pkg.sv ----
// Constants and types shared by the regulator supervisor and its serial port.
// Assumes a 20 MHz system clock; all timing counts are derived from that rate.
package bfc_pkg;
    // Bus identity and register map
    localparam logic [6:0] I2C_ADDR = 7'h5B;
    localparam logic [7:0] REG_VOUT = 8'h00;
    localparam logic [7:0] REG_CONTROL_REG_ONE = 8'h01;
    localparam logic [7:0] REG_CONTROL_REG_TWO = 8'h02;
    localparam logic [7:0] REG_FAULT = 8'h03;
    // Field positions
    localparam int C1_TON_LSB = 0;
    localparam int C1_DLY_LSB = 2;
    localparam int C1_SWEN = 4;
    localparam int C2_SLEW_LSB = 0;
    localparam int C2_DISCH = 4;
    localparam int C2_NOFULL = 5;
    localparam int C2_OTRST = 6;
    localparam int F_PG = 0;
    localparam int F_SSD = 1;
    localparam int F_HIC = 2;
    localparam int F_WARN = 3;
    localparam int F_OT = 4;
    localparam int F_LATCH = 5;
    // Power-up values
    localparam logic [7:0] VOUT_RST = 8'h00;
    localparam logic [7:0] CONTROL_REG_ONE_RST = 8'h10;
    localparam logic [7:0] CONTROL_REG_TWO_RST = 8'h00;
    // Timing
    localparam int CLK_MHZ = 20;
    localparam int BLANK_NS = 65000;
    localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int DLY0_US = 250;
    localparam int DLY1_US = 1000;
    localparam int DLY2_US = 2000;
    localparam int DLY3_US = 3000;
    localparam int COOL_US = 1000;
    // Ramp: 420 ns/mV plus 200 ns/mV per slew code, per 5 mV code step
    localparam int RAMP_BASE_NS = 420;
    localparam int RAMP_INC_NS = 200;
    localparam int STEP_MV = 5;
    localparam int RAMP_BASE_CYC = RAMP_BASE_NS * STEP_MV * CLK_MHZ / 1000;
    localparam int RAMP_INC_CYC = RAMP_INC_NS * STEP_MV * CLK_MHZ / 1000;
    localparam logic [1:0] MAX_TRIES = 2'h3;
    localparam logic [7:0] WIDE_KNEE = 8'h44;
    typedef enum logic [2:0] {
        PS_OFF = 3'b000, PS_DELAY = 3'b001, PS_RAMP = 3'b010,
        PS_RUN = 3'b011, PS_COOL = 3'b100, PS_LATCH = 3'b101
    } bfc_pwr_t;
    typedef enum logic [2:0] {
        IS_IDLE = 3'b000, IS_ADDR = 3'b001, IS_PTR = 3'b010,
        IS_WR = 3'b011, IS_RD = 3'b100
    } bfc_i2c_t;
endpackage

// ---- verification/bfc_host.sv ----
// Serial host model that reaches the regulator's register port.
// Assumes SDA has a pull-up; the bench joins both parties' pulls.
`timescale 1ns/1ps
`default_nettype none
module bfc_host (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_pull_o
);
    // Idle bus: SCL stands high and SDA is released outside frames
    initial
    begin
        scl_o = 1'h1;
        sda_pull_o = 1'h0;
    end
    // A quarter of the 400 ns SCL period, stepped on falling clock edges
    task automatic qtr;
        repeat (2) @(negedge clk_i);
    endtask
    // START from idle, or repeated START with SCL low
    task automatic start;
        sda_pull_o = 1'h0;
        qtr();
        scl_o = 1'h1;
        qtr();
        sda_pull_o = 1'h1;
        qtr();
        scl_o = 1'h0;
        qtr();
    endtask
    task automatic stop;
        sda_pull_o = 1'h1;
        qtr();
        scl_o = 1'h1;
        qtr();
        sda_pull_o = 1'h0;
        qtr();
    endtask
    // Data moves only while SCL is low, so it is never read as START or STOP
    task automatic bit_io(input logic b, output logic r);
        sda_pull_o = ~b;
        qtr();
        scl_o = 1'h1;
        qtr();
        r = sda_i;
        qtr();
        scl_o = 1'h0;
        qtr();
    endtask
    // Whole bytes, MSB first, ninth bit is the acknowledge
    task automatic tx(input logic [7:0] d, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'h1, nak);
    endtask
    task automatic rx(input logic nak, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'h1, d[i]);
        bit_io(nak, r);
    endtask
endmodule
`default_nettype wire

// ---- verification/bfc_ctrl_tb.sv ----
// Self-checking bench for the regulator supervisor and its serial port.
// Assumes bfc_host as bus master; comparator and fault pins driven here.
`timescale 1ns/1ps
`default_nettype none
module bfc_ctrl_tb;
    typedef struct {logic [7:0] p; logic [7:0] w; logic [7:0] r;} bfc_row_t;
    logic clk, rst_n, en, input_undervoltage_lockout, pr, pf, tw, ts, tc, hic, dmax, vlow;
    logic scl, pull, sda, sda_o, sda_oe_n, pg_o, pg_oe_n, sw, hs, dis, a;
    logic [1:0] ots;
    logic [7:0] code, rd;
    logic [11:0] mv;
    int fail_count = 0;
    int cmp_count = 0;
    logic [7:0] rstv [4] = '{8'h00, 8'h10, 8'h00, 8'h00};
    // Last rows leave restart enabled and a small code for short ramps
    bfc_row_t rows [8] = '{'{8'h01, 8'h11, 8'h11}, '{8'h01, 8'h12, 8'h12},
        '{8'h01, 8'h13, 8'h13}, '{8'h01, 8'h10, 8'h10}, '{8'h02, 8'h40, 8'h40},
        '{8'h02, 8'h50, 8'h50}, '{8'h00, 8'h04, 8'h04}, '{8'h07, 8'hAA, 8'h00}};
    // Open-drain SDA: low if either party pulls
    assign sda = ~pull & sda_oe_n;
    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    // Short delay and cool-off counts keep the run brief
    bfc_ctrl #(.DLY0_CYC(20), .DLY1_CYC(30), .DLY2_CYC(40), .DLY3_CYC(50),
        .COOL_CYC(20)) i_dut (.clk_i(clk), .rst_n_i(rst_n), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .en_i(en),
        .input_undervoltage_lockout_i(input_undervoltage_lockout), .pg_rise_i(pr), .pg_fall_i(pf), .temp_warn_i(tw),
        .temp_shut_i(ts), .temp_cool_i(tc), .hiccup_i(hic), .duty_max_i(dmax),
        .vout_low_i(vlow), .pg_o(pg_o), .pg_oe_n_o(pg_oe_n), .switch_en_o(sw),
        .hs_hold_o(hs), .discharge_o(dis), .on_time_select_o(ots),
        .target_code_o(code), .target_mv_o(mv));
    bfc_host i_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
    task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
        cmp_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("[FAIL] %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict;
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Bounded wait on the target code or on the switch enable
    task automatic wait_on(input logic [7:0] e, input bit on_code);
        int i;
        for (i = 0; i < 4000; i++)
        begin
            if ((on_code ? code : {7'h00, sw}) === e)
                break;
            tick(1);
        end
        if (i == 4000)
        begin
            fail_count++;
            $display("[FAIL] wait exp %h seen timeout", e);
            give_verdict();
        end
    endtask
    task automatic reg_wr(input logic [7:0] p, input logic [7:0] d);
        logic x, y, z;
        i_host.start();
        i_host.tx({bfc_pkg::I2C_ADDR, 1'h0}, x);
        i_host.tx(p, y);
        i_host.tx(d, z);
        i_host.stop();
        chk("wr ack", x | y | z, 1'h0);
    endtask
    task automatic reg_rd(input logic [7:0] p, output logic [7:0] d);
        logic x, y, z;
        i_host.start();
        i_host.tx({bfc_pkg::I2C_ADDR, 1'h0}, x);
        i_host.tx(p, y);
        i_host.start();
        i_host.tx({bfc_pkg::I2C_ADDR, 1'h1}, z);
        i_host.rx(1'h1, d);
        i_host.stop();
        chk("rd ack", x | y | z, 1'h0);
    endtask
    initial
    begin
        {rst_n, en, input_undervoltage_lockout, pr, pf, tw, ts, hic, dmax, vlow} = '0;
        tc = 1'h1;
        tick(5);
        rst_n = 1'h1;
        tick(5);
        foreach (rstv[i])
        begin
            reg_rd(8'(i), rd);
            chk("reset reg", rd, rstv[i]);
        end
        // A neighbouring address must be left unanswered
        i_host.start();
        i_host.tx(8'hB8, a);
        i_host.stop();
        chk("foreign ack", a, 1'h1);
        $display("reset and address done");
        // Register rows, written with enable low
        foreach (rows[i])
        begin
            reg_wr(rows[i].p, rows[i].w);
            reg_rd(rows[i].p, rd);
            chk("reg data", rd, rows[i].r);
            if (rows[i].p == 8'h01)
                chk("on time", ots, rows[i].w[1:0]);
            if (rows[i].p == 8'h02)
                chk("discharge", dis, rows[i].w[4]);
        end
        $display("register table done");
        // Start-up, blanking of a short comparator pulse, then power-good
        en = 1'h1;
        wait_on(8'h01, 1'h0);
        wait_on(8'h04, 1'h1);
        pr = 1'h1;
        tick(600);
        chk("target mv", mv, 12'h26C);
        pr = 1'h0;
        chk("blank", pg_oe_n, 1'h0);
        tick(5);
        pr = 1'h1;
        tick(bfc_pkg::BLANK_CYC + 5);
        chk("pg up", pg_oe_n, 1'h1);
        reg_rd(8'h03, rd);
        chk("run flags", rd, 8'h03);
        dmax = 1'h1;
        tick(5);
        chk("hs hold", hs, 1'h1);
        reg_wr(8'h02, 8'h70);
        chk("hs off", hs, 1'h0);
        dmax = 1'h0;
        en = 1'h0;
        tick(4);
        chk("pg drop", pg_oe_n, 1'h0);
        reg_rd(8'h02, rd);
        chk("ctrl kept", rd, 8'h70);
        $display("start-up done");
        // New code on the fly, then four hiccups without power-good
        en = 1'h1;
        wait_on(8'h04, 1'h1);
        reg_wr(8'h00, 8'h06);
        wait_on(8'h06, 1'h1);
        repeat (4)
        begin
            wait_on(8'h01, 1'h0);
            hic = 1'h1;
            tick(3);
            hic = 1'h0;
            wait_on(8'h00, 1'h0);
        end
        tick(50);
        chk("latched", sw, 1'h0);
        reg_rd(8'h03, rd);
        chk("latch flag", rd, 8'h20);
        $display("hiccup latch done");
        // Restart disabled: first thermal trip latches; flag is sticky
        en = 1'h0;
        reg_wr(8'h02, 8'h10);
        en = 1'h1;
        wait_on(8'h06, 1'h1);
        tw = 1'h1;
        reg_rd(8'h03, rd);
        chk("warn", rd, 8'h0A);
        ts = 1'h1;
        tick(5);
        chk("trip off", sw, 1'h0);
        reg_rd(8'h03, rd);
        chk("trip flags", rd, 8'h30);
        {ts, tw} = 2'h0;
        tick(50);
        chk("stay off", sw, 1'h0);
        reg_wr(8'h03, 8'h00);
        reg_rd(8'h03, rd);
        chk("ot clear", rd, 8'h20);
        $display("thermal done");
        // Lockout keeps switches off and power-good low
        en = 1'h0;
        tick(5);
        input_undervoltage_lockout = 1'h1;
        en = 1'h1;
        tick(100);
        chk("input_undervoltage_lockout sw", sw, 1'h0);
        chk("input_undervoltage_lockout pg", pg_oe_n, 1'h0);
        $display("lockout done");
        give_verdict();
    end
endmodule
`default_nettype wire
